//--- hw/tlw_pkg.sv
// shared constants for the tick, supply detect and interrupt flag block
package tlw_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [4:0] TICK_CONTROL_OFS  = 5'h00;
   localparam logic [4:0] SUPPLY_CTRL_OFS   = 5'h04;
   localparam logic [4:0] IRQ_FLAG_OFS      = 5'h08;
   localparam logic [4:0] IRQ_ENABLE_OFS    = 5'h0C;
   localparam logic [4:0] IRQ_STATUS_OFS    = 5'h10;

   // reset values
   localparam logic [7:0] TICK_CONTROL_RST  = 8'h37;
   localparam logic [7:0] SUPPLY_CTRL_RST   = 8'h00;
   localparam logic [7:0] IRQ_FLAG_RST      = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RST    = 8'h00;

   // tick control fields
   localparam int TICK_ON_BIT    = 7;
   localparam int TICK_SRC_BIT   = 6;
   localparam int TICK1_SEL_LSB  = 4;
   localparam int TICK0_SEL_LSB  = 0;
   localparam logic [7:0] TICK_CONTROL_MASK = 8'hF7;

   // supply detect control fields
   localparam int UV_FLAG_BIT    = 5;
   localparam int UV_ON_BIT      = 4;
   localparam int TRIP_SEL_LSB   = 0;
   localparam logic [7:0] SUPPLY_CTRL_MASK  = 8'h17;

   // request flag and enable bit positions
   localparam int TICK0_FLAG_BIT = 0;
   localparam int TICK1_FLAG_BIT = 1;
   localparam int SUPPLY_BIT     = 2;
   localparam int PMATCH_BIT     = 3;
   localparam int AMATCH_BIT     = 4;
   localparam int BMATCH_BIT     = 5;
   localparam int GROUP_EN_BIT   = 6;
   localparam int GLOBAL_EN_BIT  = 7;
   localparam int NUM_FLAGS      = 6;

   // status register fields
   localparam int ST_GROUP_FLAG  = 0;
   localparam int ST_STACK_FULL  = 1;
   localparam int ST_UV_FLAG     = 2;
   localparam int ST_VEC_REQ     = 3;

   // tick divider: base periods 2^8 and 2^12 tick-clock periods
   localparam int TICK0_BASE_LOG = 8;
   localparam int TICK1_BASE_LOG = 12;
   localparam int TICK_CNT_W     = 15;
   localparam logic [1:0] SYS_PRESCALE_LAST = 2'h3;

   // supply interrupt delay after the undervolt flag rises
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int SUPPLY_DELAY_NS = 1000;
   localparam int SUPPLY_DELAY_CYC =
      (SUPPLY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DELAY_CNT_W = $clog2(SUPPLY_DELAY_CYC + 1);
endpackage : tlw_pkg

//--- hw/tlw_tick_div.sv
// free running tick divider with two selectable wrap outputs
`timescale 1ns/100ps
module tlw_tick_div #(
   parameter int CNT_W = tlw_pkg::TICK_CNT_W     // divider width
) (
   input  wire logic       clk,       // system clock
   input  wire logic       rst_n,     // async reset, active low
   input  wire logic       runEn,     // divider running
   input  wire logic       tickStep,  // one tick-clock period elapsed
   input  wire logic [2:0] sel0,      // period code of output zero
   input  wire logic [1:0] sel1,      // period code of output one
   output logic            wrap0,     // output zero wraps, pulse
   output logic            wrap1      // output one wraps, pulse
);
   import tlw_pkg::*;

   if (CNT_W < TICK_CNT_W) begin : g_chk
      $error("tlw_tick_div: CNT_W too small for longest period");
   end

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] mask0;
   logic [CNT_W-1:0] mask1;

   // low ones masks of the selected periods
   always_comb begin
      mask0 = CNT_W'((33'h1 << (TICK0_BASE_LOG + int'(sel0))) - 33'h1);
      mask1 = CNT_W'((33'h1 << (TICK1_BASE_LOG + int'(sel1))) - 33'h1);
   end

   // binary counter, stopped and cleared while the generator is off
   always_comb begin
      cnt_d = cnt_q;
      if (!runEn) begin
         cnt_d = '0;
      end else if (tickStep) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // wrap happens on the step taken while the masked bits are all ones
   assign wrap0 = runEn && tickStep && ((cnt_q & mask0) == mask0);
   assign wrap1 = runEn && tickStep && ((cnt_q & mask1) == mask1);
endmodule : tlw_tick_div

//--- hw/tlw_timebase_irq.sv
// tick generator, supply detector and multi-function flag logic
// Overview of operation
// - tick source select picks sub-clock at 0, system clock over four at 1
// - tick one period code picks 4096 to 32768 tick-clock periods
// - tick zero period code picks 256 doubling up to 32768 periods
// - tick generator runs only while its on bit is set
// - each tick divider overflow sets that output's own request flag
// - low supply sets supply flag; vector needs all enables and free stack
// - supply service clears global enable and group flag, keeps supply flag
// - timer modules give period, A and B match flags with enables
// - timer vector needs enables and free stack; service keeps timer flags
// - any request flag rising wakes from sleep or idle regardless of enables
// - set flags stay set until cleared by a flag register write, enable or not
// - entry pushes only program counter; routine saves other registers itself
// - interrupt return sets global enable; plain return leaves it clear
// - three-bit threshold selects one of eight trip levels 2.0V to 4.0V
// - read-only undervolt flag is 1 below trip level, 0 above
// - detector-on bit powers detector; clearing it switches detector off
// - detector stays active in power-down while its on bit is high
// - supply flag rises only a fixed delay after undervolt flag rises
// - undervolt flag toggles freely near the trip level, unfiltered
`timescale 1ns/100ps
module tlw_timebase_irq #(
   parameter int DELAY_CYC = tlw_pkg::SUPPLY_DELAY_CYC  // supply irq delay
) (
   input  wire logic        clk,          // system clock, 250 MHz
   input  wire logic        rst_n,        // async reset, active low
   // wishbone classic slave
   input  wire logic        wb_cyc_i,     // bus cycle
   input  wire logic        wb_stb_i,     // strobe
   input  wire logic        wb_we_i,      // write enable
   input  wire logic [4:0]  wb_adr_i,     // byte address
   input  wire logic [3:0]  wb_sel_i,     // byte lanes
   input  wire logic [31:0] wb_dat_i,     // write data
   output logic [31:0]      wb_dat_o,     // read data
   output logic             wb_ack_o,     // acknowledge
   // tick clock source
   input  wire logic        subClk,       // low-speed sub-clock level
   // timer module comparator matches
   input  wire logic        periodMatch,  // period match pulse
   input  wire logic        aMatch,       // A match pulse
   input  wire logic        bMatch,       // B match pulse
   // supply detector analog side
   input  wire logic        detectorRaw,  // async comparator output
   output logic             detectorOn,   // powers detector circuits
   output logic [2:0]       tripLevelSel, // trip level code
   // processor core
   input  wire logic        stackFull,    // stack has no free entry
   input  wire logic        vecTaken,     // core takes group vector, pulse
   input  wire logic        irqReturn,    // interrupt return executed
   output logic             groupVecReq,  // group vector request, level
   output logic             wakeUp        // wake from sleep or idle, pulse
);
   import tlw_pkg::*;

   if (DELAY_CYC < 1 || DELAY_CYC >= (1 << DELAY_CNT_W)) begin : g_chk
      $error("tlw_timebase_irq: DELAY_CYC out of range");
   end

   // ---------------- register bus ----------------
   logic [7:0]  tickCtl_q;
   logic [7:0]  tickCtl_d;
   logic [7:0]  supCtl_q;
   logic [7:0]  supCtl_d;
   logic [7:0]  enable_q;
   logic [7:0]  enable_d;
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic        wrAcc;
   logic [7:0]  wbyte;

   // flags and status
   logic [NUM_FLAGS-1:0] flag_q;
   logic [NUM_FLAGS-1:0] flag_d;
   logic [NUM_FLAGS-1:0] flagSet;
   logic                 groupFlag_q;
   logic                 groupFlag_d;
   logic                 wake_q;
   logic                 wake_d;
   logic                 uvFlag;
   logic                 groupEvent;

   // tick clock
   logic       subClk_q;
   logic [1:0] pre_q;
   logic [1:0] pre_d;
   logic       tickStep;
   logic       wrap0;
   logic       wrap1;

   // supply detector path
   logic                   sync1_q;
   logic                   sync2_q;
   logic                   uvPrev_q;
   logic [DELAY_CNT_W-1:0] dly_q;
   logic [DELAY_CNT_W-1:0] dly_d;
   logic                   dlyRun_q;
   logic                   dlyRun_d;
   logic                   supplyEvent;

   // write to byte lane zero of an accepted write
   assign wrAcc = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   // control registers and bus answer
   always_comb begin
      tickCtl_d = tickCtl_q;
      supCtl_d  = supCtl_q;
      enable_d  = enable_q;
      ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
      rdat_d    = '0;
      if (wrAcc) begin
         case (wb_adr_i)
            TICK_CONTROL_OFS: tickCtl_d = wbyte & TICK_CONTROL_MASK;
            SUPPLY_CTRL_OFS: supCtl_d = wbyte & SUPPLY_CTRL_MASK;
            IRQ_ENABLE_OFS: enable_d = wbyte;
            default: ;
         endcase
      end
      // core entry and return steer the global enable
      if (vecTaken) begin
         enable_d[GLOBAL_EN_BIT] = 1'b0;
      end else if (irqReturn) begin
         enable_d[GLOBAL_EN_BIT] = 1'b1;
      end
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
         case (wb_adr_i)
            TICK_CONTROL_OFS: rdat_d[7:0] = tickCtl_q;
            SUPPLY_CTRL_OFS: begin
               rdat_d[7:0] = supCtl_q;
               rdat_d[UV_FLAG_BIT] = uvFlag;
            end
            IRQ_FLAG_OFS: rdat_d[NUM_FLAGS-1:0] = flag_q;
            IRQ_ENABLE_OFS: rdat_d[7:0] = enable_q;
            IRQ_STATUS_OFS: begin
               rdat_d[ST_GROUP_FLAG] = groupFlag_q;
               rdat_d[ST_STACK_FULL] = stackFull;
               rdat_d[ST_UV_FLAG]    = uvFlag;
               rdat_d[ST_VEC_REQ]    = groupVecReq;
            end
            default: rdat_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCtl_q <= TICK_CONTROL_RST;
         supCtl_q  <= SUPPLY_CTRL_RST;
         enable_q  <= IRQ_ENABLE_RST;
         ack_q     <= 1'b0;
         rdat_q    <= '0;
      end else begin
         tickCtl_q <= tickCtl_d;
         supCtl_q  <= supCtl_d;
         enable_q  <= enable_d;
         ack_q     <= ack_d;
         rdat_q    <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ---------------- tick generator ----------------
   // tick clock step: sub-clock rising edge or every fourth system clock
   always_comb begin
      pre_d = pre_q + 2'h1;
      if (tickCtl_q[TICK_SRC_BIT]) begin
         tickStep = (pre_q == SYS_PRESCALE_LAST);
      end else begin
         tickStep = subClk && !subClk_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q    <= '0;
         subClk_q <= 1'b0;
      end else begin
         pre_q    <= pre_d;
         subClk_q <= subClk;
      end
   end

   tlw_tick_div #(
      .CNT_W (TICK_CNT_W)
   ) u_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .runEn    (tickCtl_q[TICK_ON_BIT]),
      .tickStep (tickStep),
      .sel0     (tickCtl_q[TICK0_SEL_LSB +: 3]),
      .sel1     (tickCtl_q[TICK1_SEL_LSB +: 2]),
      .wrap0    (wrap0),
      .wrap1    (wrap1)
   );

   // ---------------- supply detector ----------------
   assign detectorOn   = supCtl_q[UV_ON_BIT];
   assign tripLevelSel = supCtl_q[TRIP_SEL_LSB +: 3];

   // two-stage synchroniser of the comparator output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= detectorRaw;
         sync2_q <= sync1_q;
      end
   end

   // flag follows every transition while the detector is powered
   assign uvFlag = sync2_q && detectorOn;

   // delay from undervolt rise to supply request
   always_comb begin
      dlyRun_d    = dlyRun_q;
      dly_d       = dly_q;
      supplyEvent = 1'b0;
      if (!uvFlag) begin
         dlyRun_d = 1'b0;
         dly_d    = '0;
      end else if (!uvPrev_q) begin
         dlyRun_d = 1'b1;
         dly_d    = DELAY_CNT_W'(1);
      end else if (dlyRun_q) begin
         if (dly_q == DELAY_CNT_W'(DELAY_CYC)) begin
            supplyEvent = 1'b1;
            dlyRun_d    = 1'b0;
         end else begin
            dly_d = dly_q + DELAY_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uvPrev_q <= 1'b0;
         dlyRun_q <= 1'b0;
         dly_q    <= '0;
      end else begin
         uvPrev_q <= uvFlag;
         dlyRun_q <= dlyRun_d;
         dly_q    <= dly_d;
      end
   end

   // ---------------- request flags ----------------
   // hardware set events per flag
   always_comb begin
      flagSet                 = '0;
      flagSet[TICK0_FLAG_BIT] = wrap0;
      flagSet[TICK1_FLAG_BIT] = wrap1;
      flagSet[SUPPLY_BIT]     = supplyEvent;
      flagSet[PMATCH_BIT]     = periodMatch;
      flagSet[AMATCH_BIT]     = aMatch;
      flagSet[BMATCH_BIT]     = bMatch;
   end

   // software writes set or clear; a hardware set in the same cycle wins
   generate
      for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
         always_comb begin
            flag_d[i] = flag_q[i];
            if (wrAcc && wb_adr_i == IRQ_FLAG_OFS) begin
               flag_d[i] = wbyte[i];
            end
            if (flagSet[i]) begin
               flag_d[i] = 1'b1;
            end
         end
      end
   endgenerate

   // group flag: an enabled supply or timer source raised its flag
   always_comb begin
      groupEvent = |(flagSet[BMATCH_BIT:SUPPLY_BIT] &
                     enable_q[BMATCH_BIT:SUPPLY_BIT]);
      groupFlag_d = groupFlag_q;
      if (vecTaken) begin
         groupFlag_d = 1'b0;
      end
      if (groupEvent) begin
         groupFlag_d = 1'b1;
      end
      // wake on any flag going low to high, enables ignored
      wake_d = |(flag_d & ~flag_q);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q      <= IRQ_FLAG_RST[NUM_FLAGS-1:0];
         groupFlag_q <= 1'b0;
         wake_q      <= 1'b0;
      end else begin
         flag_q      <= flag_d;
         groupFlag_q <= groupFlag_d;
         wake_q      <= wake_d;
      end
   end

   assign wakeUp = wake_q;

   // vector request; the core pushes only its program counter on entry
   assign groupVecReq = groupFlag_q && enable_q[GROUP_EN_BIT] &&
                        enable_q[GLOBAL_EN_BIT] && !stackFull;
endmodule : tlw_timebase_irq

//--- tb/test_tlw_timebase_irq.sv
// self-checking bench for the tick, supply detect and irq flag block
`timescale 1ns/100ps
module test_tlw_timebase_irq;
   import tlw_pkg::*;
   localparam int DLY = 4;
   logic        clk = 1'b0;
   logic        subClk = 1'b0;
   logic        rst_n, cyc, stb, we, raw, stackFull;
   logic        ack, detOn, vecReq, wakeUp, vecTaken, irqRet;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [2:0]  trip, mt;
   logic [7:0]  d;
   logic [31:0] wdat, rdat, q;
   int          n_mismatch, cmp_count, cycN, wakeN, vecN, retN, w, v;

   tlw_timebase_irq #(.DELAY_CYC(DLY)) DUT (.clk(clk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .subClk(subClk), .periodMatch(mt[0]), .aMatch(mt[1]),
      .bMatch(mt[2]), .detectorRaw(raw), .detectorOn(detOn),
      .tripLevelSel(trip), .stackFull(stackFull), .vecTaken(vecTaken),
      .irqReturn(irqRet), .groupVecReq(vecReq), .wakeUp(wakeUp));
   tlw_core_model u_core (.clk(clk), .rst_n(rst_n),
      .groupVecReq(vecReq), .vecTaken(vecTaken), .irqReturn(irqRet));

   // 250 MHz clock
   always #2 clk = ~clk;
   // sub-clock, event counters and hang limit
   always @(posedge clk) begin
      cycN++;
      subClk <= cycN[1];
      if (wakeUp === 1'b1) wakeN++;
      if (vecTaken === 1'b1) vecN++;
      if (irqRet === 1'b1) retN++;
      if (cycN == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   function automatic int tcyc(input int base, input int s);
      return (base << s) * 4;
   endfunction : tcyc
   task automatic report_and_stop();
      $display("TB: %0d mismatches in %0d checks", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk
   task automatic bus(input logic [4:0] a, input logic wr,
                      input logic [7:0] dd);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= wr;
      adr  <= a;
      wdat <= {24'h0, dd};
      @(posedge clk);
      // only the bench cycle limit ends this wait
      while (ack !== 1'b1) begin
         @(posedge clk);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rc(input logic [4:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string nm);
      bus(a, 1'b0, 8'h00);
      chk(nm, e & m, q & m);
   endtask : rc
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic pm(input int i);
      mt[i] <= 1'b1;
      @(posedge clk);
      mt <= 3'h0;
      @(posedge clk);
   endtask : pm
   task automatic wait_ev(input int base, input bit r);
      int n;
      n = 0;
      while (((r ? retN : vecN) == base) && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_ev

   // main sequence
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, raw, stackFull} = 5'h00;
      adr = 5'h00;
      sel = 4'h1;
      wdat = 32'h0;
      mt = 3'h0;
      void'($urandom(27));
      wt(2);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(TICK_CONTROL_OFS, 32'hFFFFFFFF, 32'h37, "tick rst");
      rc(SUPPLY_CTRL_OFS, 32'hFFFFFFFF, 32'h0, "supply rst");
      rc(IRQ_FLAG_OFS, 32'hFFFFFFFF, 32'h0, "flag rst");
      rc(IRQ_ENABLE_OFS, 32'hFFFFFFFF, 32'h0, "enable rst");
      bus(5'h14, 1'b1, 8'hFF);
      rc(5'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
      d = 8'($urandom()) & 8'h7F;
      bus(TICK_CONTROL_OFS, 1'b1, d);
      rc(TICK_CONTROL_OFS, 32'hFF, 32'(d & 8'hF7), "tick ctl");
      // write with lane zero off must be ignored
      sel <= 4'h0;
      bus(TICK_CONTROL_OFS, 1'b1, 8'hFF);
      sel <= 4'h1;
      rc(TICK_CONTROL_OFS, 32'hFF, 32'(d & 8'hF7), "lane off");
      for (int t = 0; t < 8; t++) begin
         d = 8'($urandom());
         d[2:0] = 3'(t);
         bus(SUPPLY_CTRL_OFS, 1'b1, d);
         rc(SUPPLY_CTRL_OFS, 32'hFF, 32'(d & 8'h17), "supply ctl");
         chk("trip", 32'(t), 32'(trip));
         chk("det on", 32'(d[4]), 32'(detOn));
      end
      bus(IRQ_FLAG_OFS, 1'b1, 8'h00);
      bus(TICK_CONTROL_OFS, 1'b1, 8'h40);
      wt(1200);
      rc(IRQ_FLAG_OFS, 32'h3, 32'h0, "tick off");
      for (int s = 0; s < 2; s++) begin
         d = {1'b1, s[0], 3'h0, 3'($urandom_range(1))};
         bus(TICK_CONTROL_OFS, 1'b1, 8'h00);
         bus(IRQ_FLAG_OFS, 1'b1, 8'h00);
         bus(TICK_CONTROL_OFS, 1'b1, d);
         wt(tcyc(256, d[2:0]) * 9 / 10);
         rc(IRQ_FLAG_OFS, 32'h3, 32'h0, "tick early");
         wt(tcyc(256, d[2:0]) / 5);
         rc(IRQ_FLAG_OFS, 32'h3, 32'h1, "tick0");
      end
      bus(TICK_CONTROL_OFS, 1'b1, 8'h00);
      bus(IRQ_FLAG_OFS, 1'b1, 8'h00);
      bus(TICK_CONTROL_OFS, 1'b1, 8'hC0);
      wt(tcyc(4096, 0) * 19 / 20);
      rc(IRQ_FLAG_OFS, 32'h2, 32'h0, "tick1 early");
      wt(tcyc(4096, 0) / 10);
      rc(IRQ_FLAG_OFS, 32'h2, 32'h2, "tick1");
      bus(TICK_CONTROL_OFS, 1'b1, 8'h00);
      bus(SUPPLY_CTRL_OFS, 1'b1, 8'h00);
      for (int i = 0; i < 3; i++) begin
         bus(IRQ_FLAG_OFS, 1'b1, 8'h00);
         w = wakeN;
         pm(i);
         wt(2);
         chk("wake", 32'(w + 1), 32'(wakeN));
         rc(IRQ_FLAG_OFS, 32'h38, 32'h8 << i, "match");
         pm(i);
         wt(2);
         chk("no rewake", 32'(w + 1), 32'(wakeN));
      end
      bus(IRQ_FLAG_OFS, 1'b1, 8'h00);
      bus(IRQ_ENABLE_OFS, 1'b1, 8'hC8);
      stackFull <= 1'b1;
      pm(0);
      wt(3);
      chk("stack full", 32'h0, 32'(vecReq));
      rc(IRQ_STATUS_OFS, 32'h1, 32'h1, "group set");
      v = vecN;
      w = retN;
      stackFull <= 1'b0;
      wait_ev(v, 0);
      chk("pm vector", 32'(v + 1), 32'(vecN));
      rc(IRQ_ENABLE_OFS, 32'h80, 32'h0, "global off");
      rc(IRQ_FLAG_OFS, 32'h8, 32'h8, "pm kept");
      rc(IRQ_STATUS_OFS, 32'h1, 32'h0, "group clr");
      wait_ev(w, 1);
      rc(IRQ_ENABLE_OFS, 32'h80, 32'h80, "global on");
      bus(IRQ_FLAG_OFS, 1'b1, 8'h00);
      bus(IRQ_ENABLE_OFS, 1'b1, 8'hC4);
      bus(SUPPLY_CTRL_OFS, 1'b1, 8'h13);
      wt(4);
      raw <= 1'b1;
      wt(3);
      raw <= 1'b0;
      wt(20);
      rc(IRQ_FLAG_OFS, 32'h4, 32'h0, "short dip");
      v = vecN;
      // hold the vector back so the core return cannot race the reads
      stackFull <= 1'b1;
      raw <= 1'b1;
      rc(IRQ_FLAG_OFS, 32'h4, 32'h0, "supply early");
      wt(2 * DLY + 4);
      rc(IRQ_STATUS_OFS, 32'h4, 32'h4, "uv flag");
      chk("uv held", 32'(v), 32'(vecN));
      stackFull <= 1'b0;
      wait_ev(v, 0);
      chk("uv vector", 32'(v + 1), 32'(vecN));
      rc(IRQ_FLAG_OFS, 32'h4, 32'h4, "supply kept");
      rc(IRQ_ENABLE_OFS, 32'h80, 32'h0, "uv global off");
      bus(SUPPLY_CTRL_OFS, 1'b1, 8'h03);
      wt(4);
      rc(IRQ_STATUS_OFS, 32'h4, 32'h0, "det off");
      raw <= 1'b0;
      report_and_stop();
   end
endmodule : test_tlw_timebase_irq

//--- tb/tlw_core_model.sv
// processor core model taking the group vector
`timescale 1ns/100ps
module tlw_core_model (
   input  logic clk,         // clock
   input  logic rst_n,       // reset
   input  logic groupVecReq, // vector request
   output logic vecTaken,    // vector entry pulse
   output logic irqReturn    // return pulse
);
   int waitQ;
   int pcDepth;
   // take vector after a random delay, return from service later
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vecTaken  <= 1'b0;
         irqReturn <= 1'b0;
         waitQ     <= 0;
         pcDepth   <= 0;
      end else begin
         vecTaken  <= 1'b0;
         irqReturn <= 1'b0;
         if (waitQ > 0)
            waitQ <= waitQ - 1;
         else if (pcDepth > 0) begin
            irqReturn <= 1'b1;
            pcDepth   <= pcDepth - 1;
         end else if (groupVecReq && $urandom_range(1) == 1) begin
            vecTaken <= 1'b1;
            pcDepth  <= pcDepth + 1;
            waitQ    <= $urandom_range(30, 10);
         end
      end
   end
endmodule : tlw_core_model

//--- tb/tlw_timebase_irq_properties.sv
// assertion checker for the tick, supply detect and irq flag block
`timescale 1ns/100ps
module tlw_timebase_irq_chk
   import tlw_pkg::*;
#(
   parameter int DELAY_CYC = 250   // supply irq delay
) (
   input logic        clk,          // clock
   input logic        rst_n,        // reset
   input logic        wb_cyc_i,     // cycle
   input logic        wb_stb_i,     // strobe
   input logic        wb_we_i,      // write
   input logic [4:0]  wb_adr_i,     // address
   input logic [3:0]  wb_sel_i,     // lanes
   input logic [31:0] wb_dat_i,     // write data
   input logic [31:0] wb_dat_o,     // read data
   input logic        wb_ack_o,     // ack
   input logic        subClk,       // sub-clock
   input logic        periodMatch,  // period match
   input logic        aMatch,       // a match
   input logic        bMatch,       // b match
   input logic        detectorRaw,  // comparator
   input logic        detectorOn,   // detector power
   input logic [2:0]  tripLevelSel, // trip code
   input logic        stackFull,    // stack full
   input logic        vecTaken,     // vector entry
   input logic        irqReturn,    // irq return
   input logic        groupVecReq,  // vector request
   input logic        wakeUp        // wake pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic       req;
   logic       wrSup;
   logic       rdSup;
   logic       rdSt;
   logic [2:0] wTrip;
   // request decode helpers
   assign req   = wb_cyc_i && wb_stb_i;
   assign wrSup = req && wb_we_i && wb_sel_i[0] && wb_adr_i == SUPPLY_CTRL_OFS;
   assign rdSup = req && !wb_we_i && wb_adr_i == SUPPLY_CTRL_OFS;
   assign rdSt  = req && !wb_we_i && wb_adr_i == IRQ_STATUS_OFS;
   assign wTrip = wb_dat_i[2:0];

   property p_ack_next;
      req && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next:
      assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse:
      assert property (p_ack_pulse) else $error("ack too long");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle:
      assert property (p_dat_idle) else $error("data outside ack");
   property p_stack_block;
      stackFull |-> !groupVecReq;
   endproperty
   a_stack_block:
      assert property (p_stack_block) else $error("vector while stack full");
   property p_vec_clear;
      vecTaken |=> !groupVecReq;
   endproperty
   a_vec_clear:
      assert property (p_vec_clear) else $error("request after entry");
   property p_on_write;
      $changed(detectorOn) |-> $past(wrSup && !wb_ack_o);
   endproperty
   a_on_write:
      assert property (p_on_write) else $error("detector power moved");
   property p_trip_write;
      wrSup && !wb_ack_o |=> tripLevelSel == $past(wTrip);
   endproperty
   a_trip_write:
      assert property (p_trip_write) else $error("trip code not stored");
   property p_rd_sup;
      rdSup && wb_ack_o |-> wb_dat_o[7:0] ==
         {2'h0, wb_dat_o[5], detectorOn, 1'b0, tripLevelSel};
   endproperty
   a_rd_sup:
      assert property (p_rd_sup) else $error("supply control readback");
   property p_uv_sync;
      rdSt && wb_ack_o && detectorOn && $past(detectorOn, 5) &&
      $past(detectorRaw, 3) == $past(detectorRaw, 4) &&
      $past(detectorRaw, 4) == $past(detectorRaw, 5)
      |-> wb_dat_o[ST_UV_FLAG] == $past(detectorRaw, 3);
   endproperty
   a_uv_sync:
      assert property (p_uv_sync) else $error("undervolt flag wrong");
   // main scenarios reached
   c_vec: cover property (groupVecReq ##[1:4] vecTaken);
   c_wake: cover property (wakeUp);
   c_full: cover property (stackFull && periodMatch);
endmodule : tlw_timebase_irq_chk

bind tlw_timebase_irq tlw_timebase_irq_chk #(.DELAY_CYC(DELAY_CYC)) u_chk (
   .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .subClk(subClk), .periodMatch(periodMatch), .aMatch(aMatch),
   .bMatch(bMatch), .detectorRaw(detectorRaw), .detectorOn(detectorOn),
   .tripLevelSel(tripLevelSel), .stackFull(stackFull),
   .vecTaken(vecTaken), .irqReturn(irqReturn),
   .groupVecReq(groupVecReq), .wakeUp(wakeUp));
